// File: verilog/pacc_top.sv
// password access permission control with apb register slave
// Notes on behaviour
// [R1] access_enable_a bit 7 opens tables 07h and 08h to level 1.
// [R2] access_enable_a bit 6 opens aliased table F8h-FFh read/write to level 1.
// [R3] access_enable_a bit 5 opens table 02h except password bytes to level 1.
// [R4] access_enable_a bit 4, set at reset, opens table 01h 80h-BFh to level 1.
// [R5] access_enable_a bit 3, clear at reset, opens table 01h C0h-F7h to level 1.
// [R6] access_enable_a bit 2 lets level 1 write main 00h-5Fh; everyone reads.
// [R7] access_enable_a bit 1 lets level 1 write aux 00h-7Fh; everyone reads.
// [R8] access_enable_a bit 0 lets level 1 read and write aux 80h-FFh.
// [R9] access_enable_b bit 7 opens tables 04h and 06h to level 1.
// [R10] access_enable_b bit 6 gives level 1 reads of aliased F8h-FFh.
// [R11] access_enable_b bit 5 gives level 1 reads of table 02h except password.
// [R12] access_enable_b bit 4 gives level 1 reads of table 01h 80h-BFh.
// [R13] access_enable_b bit 3 gives level 1 reads of table 01h C0h-F7h.
// [R14] access_enable_b bit 2 lets level 1 overwrite the level1 password bytes.
// [R15] level1 password bytes never read back, at any level.
// [R16] access_enable_b bit 1, set at reset, lets users write aux 00h-7Fh.
// [R17] access_enable_b bit 0, set at reset, opens aux 80h-FFh to users.
// [R18] grant on level 2 except password reads, level 1 with enable, or user bits; denied writes dropped.
// [R19] user and level-1 aux write bits combine by or.
//
// Local design decision: register access over APB.
`default_nettype none
module pacc_top #(
    parameter int ADDR_W = 12
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [1:0] req_level_i,
    input wire logic req_space_i,
    input wire logic [7:0] req_table_i,
    input wire logic [7:0] req_addr_i,
    input wire logic [7:0] req_wdata_i,
    input wire logic [7:0] mem_rdata_i,
    output logic rsp_valid_o,
    output logic rsp_grant_o,
    output logic [7:0] rsp_rdata_o,
    output logic mem_we_o,
    output logic mem_space_o,
    output logic [7:0] mem_table_o,
    output logic [7:0] mem_addr_o,
    output logic [7:0] mem_wdata_o
);

    // refuse address widths that cannot reach the register block
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
        $error("pacc_top: ADDR_W must lie in 10..32");
    end

    // byte addresses of the registers
    localparam logic [ADDR_W-1:0] ADR_EN_A = ADDR_W'({pacc_pkg::IDX_EN_A, 2'b00});
    localparam logic [ADDR_W-1:0] ADR_EN_B = ADDR_W'({pacc_pkg::IDX_EN_B, 2'b00});
    localparam logic [ADDR_W-1:0] ADR_CTRL = ADDR_W'({pacc_pkg::IDX_CTRL, 2'b00});
    localparam logic [ADDR_W-1:0] ADR_STAT = ADDR_W'({pacc_pkg::IDX_STAT, 2'b00});

    // register state
    logic [7:0] en_a_q;
    logic [7:0] en_b_q;
    logic alias_q;
    logic [7:0] deny_cnt_q;
    logic deny_q;
    logic [1:0] last_lvl_q;

    // apb state
    pacc_pkg::pacc_apb_st_t st_q;
    pacc_pkg::pacc_apb_st_t st_d;
    logic [31:0] prdata_q;
    logic hit_q;

    // host response state
    logic rsp_valid_q;
    logic rsp_grant_q;
    logic [7:0] rsp_rdata_q;
    logic mem_we_q;
    logic mem_space_q;
    logic [7:0] mem_table_q;
    logic [7:0] mem_addr_q;
    logic [7:0] mem_wdata_q;

    // decoded apb access
    logic sel_en_a;
    logic sel_en_b;
    logic sel_ctrl;
    logic sel_stat;
    logic sel_any;
    logic setup;
    logic access;
    logic apb_wr;
    logic lane0_wr;
    logic apb_wr_a;
    logic apb_wr_b;
    logic apb_wr_ctrl;
    logic [31:0] rd_mux;

    // host decision
    logic [7:0] reg_rdata;
    logic [7:0] flt_rdata;
    logic host_take;
    logic host_rd_ok;
    logic host_wr_ok;
    logic host_grant;
    logic host_reg_wr;
    logic host_wr_a;
    logic host_wr_b;
    logic denied;
    logic stat_clr;

    pacc_req_if u_req ();

    // request fields toward the decoder
    assign u_req.level = pacc_pkg::pacc_level_t'(req_level_i);
    assign u_req.space = req_space_i;
    assign u_req.tbl = req_table_i;
    assign u_req.addr = req_addr_i;
    assign u_req.alias_sel = alias_q;
    assign u_req.en_a = en_a_q;
    assign u_req.en_b = en_b_q;

    pacc_decode u_decode (
        .req (u_req.dec)
    );

    pacc_rdfilter u_rdfilter (
        .req (u_req.flt),
        .mem_rdata_i (mem_rdata_i),
        .reg_rdata_i (reg_rdata),
        .rdata_o (flt_rdata)
    );

    // register value seen by the host at table 02h C0h/C1h
    assign reg_rdata = req_addr_i[0] ? en_b_q : en_a_q;

    // host decision terms
    assign host_take = ce_i & req_valid_i;
    assign host_rd_ok = u_req.rd_ok;
    assign host_wr_ok = u_req.wr_ok;
    assign host_grant = req_write_i ? host_wr_ok : host_rd_ok;
    assign host_reg_wr = host_take & req_write_i & host_wr_ok & u_req.reg_hit; // [R18]
    assign host_wr_a = host_reg_wr & ~req_addr_i[0];
    assign host_wr_b = host_reg_wr & req_addr_i[0];
    assign denied = host_take & ~host_grant;

    // apb address decode
    assign sel_en_a = (paddr_i == ADR_EN_A);
    assign sel_en_b = (paddr_i == ADR_EN_B);
    assign sel_ctrl = (paddr_i == ADR_CTRL);
    assign sel_stat = (paddr_i == ADR_STAT);
    assign sel_any = sel_en_a | sel_en_b | sel_ctrl | sel_stat;

    // apb phases
    assign setup = psel_i & ~penable_i;
    assign access = (st_q == pacc_pkg::ST_ACCESS) & psel_i & penable_i;
    assign pready_o = access & ce_i;
    assign pslverr_o = pready_o & ~hit_q;
    assign apb_wr = pready_o & pwrite_i & hit_q;
    assign lane0_wr = apb_wr & pstrb_i[0];
    assign stat_clr = lane0_wr & sel_stat;

    assign apb_wr_a = lane0_wr & sel_en_a;
    assign apb_wr_b = lane0_wr & sel_en_b;
    assign apb_wr_ctrl = lane0_wr & sel_ctrl;

    // apb read data, low byte carries each 8-bit register
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_en_a) begin
            rd_mux = {24'h00_0000, en_a_q};
        end else if (sel_en_b) begin
            rd_mux = {24'h00_0000, en_b_q};
        end else if (sel_ctrl) begin
            rd_mux = {31'h0000_0000, alias_q};
        end else if (sel_stat) begin
            rd_mux[7:0] = deny_cnt_q;
            rd_mux[pacc_pkg::STAT_DENY] = deny_q;
            rd_mux[pacc_pkg::STAT_DENY+1 +: 2] = last_lvl_q;
        end
    end

    // apb phase tracking
    always_comb begin
        case (st_q)
            pacc_pkg::ST_IDLE: begin
                st_d = setup ? pacc_pkg::ST_ACCESS : pacc_pkg::ST_IDLE;
            end
            pacc_pkg::ST_ACCESS: begin
                st_d = (access || !psel_i) ? pacc_pkg::ST_IDLE : pacc_pkg::ST_ACCESS;
            end
            default: begin
                st_d = pacc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q <= pacc_pkg::ST_IDLE;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    // read data and decode captured in the setup cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_q <= 32'h0000_0000;
            hit_q <= 1'b0;
        end else if (ce_i && st_q == pacc_pkg::ST_IDLE && setup) begin
            prdata_q <= pwrite_i ? 32'h0000_0000 : rd_mux;
            hit_q <= sel_any;
        end
    end

    assign prdata_o = prdata_q;

    // first permission register; apb write wins over a host write
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            en_a_q <= pacc_pkg::RST_EN_A; // [R4] [R5]
        end else if (ce_i) begin
            if (apb_wr_a) begin
                en_a_q <= pwdata_i[7:0];
            end else if (host_wr_a) begin
                en_a_q <= req_wdata_i; // [R3]
            end
        end
    end

    // second permission register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            en_b_q <= pacc_pkg::RST_EN_B; // [R16] [R17]
        end else if (ce_i) begin
            if (apb_wr_b) begin
                en_b_q <= pwdata_i[7:0];
            end else if (host_wr_b) begin
                en_b_q <= req_wdata_i; // [R3]
            end
        end
    end

    // table alias select for the F8h-FFh window
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            alias_q <= pacc_pkg::RST_CTRL[pacc_pkg::CTRL_ALIAS];
        end else if (ce_i && apb_wr_ctrl) begin
            alias_q <= pwdata_i[pacc_pkg::CTRL_ALIAS]; // [R2] [R10]
        end
    end

    // denial count saturates; a new denial beats a clear
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            deny_cnt_q <= 8'h00;
        end else if (ce_i) begin
            if (denied) begin
                if (stat_clr) begin
                    deny_cnt_q <= 8'h01;
                end else if (deny_cnt_q != 8'hff) begin
                    deny_cnt_q <= deny_cnt_q + 8'h01;
                end
            end else if (stat_clr) begin
                deny_cnt_q <= 8'h00;
            end
        end
    end

    // last request outcome and level
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            deny_q <= 1'b0;
            last_lvl_q <= 2'h0;
        end else if (ce_i) begin
            if (host_take) begin
                deny_q <= ~host_grant;
                last_lvl_q <= req_level_i;
            end else if (stat_clr) begin
                deny_q <= 1'b0;
            end
        end
    end

    // host response, one cycle after the request
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rsp_valid_q <= 1'b0;
            rsp_grant_q <= 1'b0;
            rsp_rdata_q <= 8'h00;
        end else if (ce_i) begin
            rsp_valid_q <= req_valid_i;
            if (req_valid_i) begin
                rsp_grant_q <= host_grant; // [R18]
                rsp_rdata_q <= req_write_i ? 8'h00 : flt_rdata; // [R15]
            end
        end
    end

    // memory write strobe only for granted writes outside the registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mem_we_q <= 1'b0;
        end else if (ce_i) begin
            mem_we_q <= req_valid_i & req_write_i & host_wr_ok & ~u_req.reg_hit; // [R18]
        end
    end

    // memory write address and data
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mem_space_q <= 1'b0;
            mem_table_q <= 8'h00;
            mem_addr_q <= 8'h00;
            mem_wdata_q <= 8'h00;
        end else if (ce_i && req_valid_i) begin
            mem_space_q <= req_space_i;
            mem_table_q <= req_table_i;
            mem_addr_q <= req_addr_i;
            mem_wdata_q <= req_wdata_i;
        end
    end

    assign rsp_valid_o = rsp_valid_q;
    assign rsp_grant_o = rsp_grant_q;
    assign rsp_rdata_o = rsp_rdata_q;
    assign mem_we_o = mem_we_q;
    assign mem_space_o = mem_space_q;
    assign mem_table_o = mem_table_q;
    assign mem_addr_o = mem_addr_q;
    assign mem_wdata_o = mem_wdata_q;

endmodule : pacc_top
`default_nettype wire

// File: verilog/pacc_pkg.sv
// constants and types for the password access permission block
`default_nettype none
package pacc_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_EN_A = 8'hc0;
    localparam logic [7:0] IDX_EN_B = 8'hc1;
    localparam logic [7:0] IDX_CTRL = 8'hc2;
    localparam logic [7:0] IDX_STAT = 8'hc3;
    // values after reset
    localparam logic [7:0] RST_EN_A = 8'h10;
    localparam logic [7:0] RST_EN_B = 8'h03;
    localparam logic [7:0] RST_CTRL = 8'h00;
    // access_enable_a fields
    localparam int A_T78 = 7;
    localparam int A_T1TOP = 6;
    localparam int A_T2 = 5;
    localparam int A_T1LOW = 4;
    localparam int A_T1MID = 3;
    localparam int A_LOWER = 2;
    localparam int A_AUXLO = 1;
    localparam int A_AUXHI = 0;
    // access_enable_b fields
    localparam int B_T46 = 7;
    localparam int B_T1TOP = 6;
    localparam int B_T2 = 5;
    localparam int B_T1LOW = 4;
    localparam int B_T1MID = 3;
    localparam int B_SECRET = 2;
    localparam int B_AUXLO_U = 1;
    localparam int B_AUXHI_U = 0;
    // control and status fields
    localparam int CTRL_ALIAS = 0;
    localparam int STAT_DENY = 8;
    // memory tables and address bounds
    localparam logic [7:0] TBL_1 = 8'h01;
    localparam logic [7:0] TBL_2 = 8'h02;
    localparam logic [7:0] TBL_4 = 8'h04;
    localparam logic [7:0] TBL_5 = 8'h05;
    localparam logic [7:0] TBL_6 = 8'h06;
    localparam logic [7:0] TBL_7 = 8'h07;
    localparam logic [7:0] TBL_8 = 8'h08;
    localparam logic [7:0] ADR_UPPER = 8'h80;
    localparam logic [7:0] ADR_LOWER_END = 8'h5f;
    localparam logic [7:0] ADR_T1_MID = 8'hc0;
    localparam logic [7:0] ADR_T1_TOP = 8'hf8;
    localparam logic [7:0] ADR_PW_LO = 8'hb0;
    localparam logic [7:0] ADR_PW_HI = 8'hb3;
    localparam logic SPACE_MAIN = 1'b0;
    localparam logic SPACE_AUX = 1'b1;
    typedef enum logic [1:0] {LVL_USER = 2'h0, LVL_ONE = 2'h1, LVL_TWO = 2'h2} pacc_level_t;
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_ACCESS = 2'b10} pacc_apb_st_t;
endpackage : pacc_pkg
`default_nettype wire

// File: verilog/pacc_req_if.sv
// request and decision signals between the top and its decoder and filter
`default_nettype none
interface pacc_req_if;
    pacc_pkg::pacc_level_t level;
    logic space;
    logic [7:0] tbl;
    logic [7:0] addr;
    logic alias_sel;
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic rd_ok;
    logic wr_ok;
    logic secret;
    logic reg_hit;
    modport src (output level, space, tbl, addr, alias_sel, en_a, en_b, input rd_ok, wr_ok, secret, reg_hit);
    modport dec (input level, space, tbl, addr, alias_sel, en_a, en_b, output rd_ok, wr_ok, secret, reg_hit);
    modport flt (input rd_ok, secret, reg_hit);
endinterface : pacc_req_if
`default_nettype wire

// File: verilog/pacc_decode.sv
// region decode and read/write permission decision
`default_nettype none
module pacc_decode (
    pacc_req_if.dec req
);
    logic l1_rd;
    logic l1_wr;
    logic usr_rd;
    logic usr_wr;
    logic is_l1;
    logic is_l2;
    logic [7:0] a;
    logic [7:0] b;

    assign a = req.en_a;
    assign b = req.en_b;
    assign is_l1 = (req.level == pacc_pkg::LVL_ONE);
    assign is_l2 = (req.level == pacc_pkg::LVL_TWO);

    always_comb begin
        l1_rd = 1'b0;
        l1_wr = 1'b0;
        usr_rd = 1'b0;
        usr_wr = 1'b0;
        req.secret = 1'b0;
        req.reg_hit = 1'b0;
        if (req.space == pacc_pkg::SPACE_AUX) begin
            if (req.addr < pacc_pkg::ADR_UPPER) begin
                usr_rd = 1'b1; // [R7]
                l1_wr = a[pacc_pkg::A_AUXLO]; // [R7] [R19]
                usr_wr = b[pacc_pkg::B_AUXLO_U]; // [R16] [R19]
            end else begin
                usr_rd = b[pacc_pkg::B_AUXHI_U]; // [R17]
                l1_rd = a[pacc_pkg::A_AUXHI]; // [R8]
                l1_wr = a[pacc_pkg::A_AUXHI]; // [R8] [R19]
                usr_wr = b[pacc_pkg::B_AUXHI_U]; // [R17] [R19]
            end
        end else if (req.addr < pacc_pkg::ADR_UPPER) begin
            usr_rd = 1'b1; // [R6]
            if (req.addr <= pacc_pkg::ADR_LOWER_END) begin
                l1_wr = a[pacc_pkg::A_LOWER]; // [R6]
            end else begin
                usr_wr = 1'b1;
            end
        end else begin
            case (req.tbl)
                pacc_pkg::TBL_1, pacc_pkg::TBL_5: begin
                    if (req.addr >= pacc_pkg::ADR_T1_TOP) begin
                        if (req.alias_sel == (req.tbl == pacc_pkg::TBL_5)) begin
                            l1_rd = a[pacc_pkg::A_T1TOP] | b[pacc_pkg::B_T1TOP]; // [R2] [R10]
                            l1_wr = a[pacc_pkg::A_T1TOP]; // [R2]
                        end
                    end else if (req.tbl == pacc_pkg::TBL_1) begin
                        if (req.addr >= pacc_pkg::ADR_T1_MID) begin
                            l1_rd = a[pacc_pkg::A_T1MID] | b[pacc_pkg::B_T1MID]; // [R5] [R13]
                            l1_wr = a[pacc_pkg::A_T1MID]; // [R5]
                        end else begin
                            l1_rd = a[pacc_pkg::A_T1LOW] | b[pacc_pkg::B_T1LOW]; // [R4] [R12]
                            l1_wr = a[pacc_pkg::A_T1LOW]; // [R4]
                        end
                    end
                end
                pacc_pkg::TBL_2: begin
                    if (req.addr >= pacc_pkg::ADR_PW_LO && req.addr <= pacc_pkg::ADR_PW_HI) begin
                        req.secret = 1'b1; // [R15]
                        l1_wr = b[pacc_pkg::B_SECRET]; // [R14]
                    end else begin
                        l1_rd = a[pacc_pkg::A_T2] | b[pacc_pkg::B_T2]; // [R3] [R11]
                        l1_wr = a[pacc_pkg::A_T2]; // [R3]
                        req.reg_hit = (req.addr == pacc_pkg::IDX_EN_A) || (req.addr == pacc_pkg::IDX_EN_B);
                    end
                end
                pacc_pkg::TBL_4, pacc_pkg::TBL_6: begin
                    l1_rd = b[pacc_pkg::B_T46]; // [R9]
                    l1_wr = b[pacc_pkg::B_T46]; // [R9]
                end
                pacc_pkg::TBL_7, pacc_pkg::TBL_8: begin
                    l1_rd = a[pacc_pkg::A_T78]; // [R1]
                    l1_wr = a[pacc_pkg::A_T78]; // [R1]
                end
                default: begin
                end
            endcase
        end
    end

    assign req.rd_ok = ~req.secret & (is_l2 | (is_l1 & l1_rd) | usr_rd); // [R18] [R15]
    assign req.wr_ok = is_l2 | (is_l1 & l1_wr) | usr_wr; // [R18]
endmodule : pacc_decode
`default_nettype wire

// File: verilog/pacc_rdfilter.sv
// read data selection that blanks denied and secret bytes
`default_nettype none
module pacc_rdfilter (
    pacc_req_if.flt req,
    input wire logic [7:0] mem_rdata_i,
    input wire logic [7:0] reg_rdata_i,
    output logic [7:0] rdata_o
);
    always_comb begin
        if (!req.rd_ok || req.secret) begin
            rdata_o = 8'h00; // [R15] [R18]
        end else if (req.reg_hit) begin
            rdata_o = reg_rdata_i;
        end else begin
            rdata_o = mem_rdata_i;
        end
    end
endmodule : pacc_rdfilter
`default_nettype wire

// File: testbench/pacc_monitor.sv
// concurrent checks on the ports of the access permission block
`default_nettype none
module pacc_monitor (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [1:0] req_level_i,
    input wire logic req_space_i,
    input wire logic [7:0] req_table_i,
    input wire logic [7:0] req_addr_i,
    input wire logic rsp_valid_o,
    input wire logic rsp_grant_o,
    input wire logic [7:0] rsp_rdata_o,
    input wire logic mem_we_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tk;
    logic pw;
    logic usr;
    assign tk = req_valid_i && ce_i;
    assign pw = tk && !req_write_i && !req_space_i && req_table_i == 8'h02 && req_addr_i inside {[8'hb0:8'hb3]};
    assign usr = req_level_i == 2'h0 || req_level_i == 2'h3;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    property p_rsp; tk |=> rsp_valid_o; endproperty
    a_rsp: assert property (p_rsp) else $error("no response after request");
    property p_rsp_src; rsp_valid_o && $past(ce_i) |-> $past(tk); endproperty
    a_rsp_src: assert property (p_rsp_src) else $error("response without request");
    property p_we; mem_we_o |-> rsp_valid_o && rsp_grant_o; endproperty
    a_we: assert property (p_we) else $error("memory write without grant");
    property p_deny; rsp_valid_o && !rsp_grant_o |-> rsp_rdata_o == 8'h00 && !mem_we_o; endproperty
    a_deny: assert property (p_deny) else $error("denied access leaked");
    property p_pw; pw |=> !rsp_grant_o && rsp_rdata_o == 8'h00; endproperty
    a_pw: assert property (p_pw) else $error("password bytes read back");
    property p_lvl2; tk && req_level_i == 2'h2 && !pw |=> rsp_grant_o; endproperty
    a_lvl2: assert property (p_lvl2) else $error("level 2 access refused");
    property p_aux_rd; tk && !req_write_i && req_space_i && req_addr_i < 8'h80 |=> rsp_grant_o; endproperty
    a_aux_rd: assert property (p_aux_rd) else $error("aux low read refused");
    property p_main_rd; tk && !req_write_i && !req_space_i && req_addr_i <= 8'h5f |=> rsp_grant_o; endproperty
    a_main_rd: assert property (p_main_rd) else $error("main low read refused");
    property p_main_wr; tk && req_write_i && !req_space_i && req_addr_i <= 8'h5f && usr |=> !rsp_grant_o; endproperty
    a_main_wr: assert property (p_main_wr) else $error("user wrote main low");
    property p_t1; tk && !req_space_i && req_table_i == 8'h01 && req_addr_i >= 8'h80 && usr |=> !rsp_grant_o;
    endproperty
    a_t1: assert property (p_t1) else $error("user reached table 1");
endmodule : pacc_monitor
bind pacc_top pacc_monitor pacc_monitor_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_level_i(req_level_i), .req_space_i(req_space_i),
    .req_table_i(req_table_i), .req_addr_i(req_addr_i), .rsp_valid_o(rsp_valid_o), .rsp_grant_o(rsp_grant_o),
    .rsp_rdata_o(rsp_rdata_o), .mem_we_o(mem_we_o));
`default_nettype wire

// File: testbench/pacc_mem_model.sv
// memory model answering byte reads for the permission block
`default_nettype none
module pacc_mem_model (
    input wire logic [7:0] req_table_i,
    input wire logic [7:0] req_addr_i,
    output logic [7:0] mem_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // pattern differs per table and byte so a wrong source shows
    assign mem_rdata_o = req_addr_i ^ req_table_i ^ 8'h3c;
endmodule : pacc_mem_model
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the password access permission block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, rsp_valid, rsp_grant, mem_we, er;
    logic [7:0] rsp_rdata, mem_rdata;
    logic rv = 1'b0, rw = 1'b0, rs = 1'b0;
    logic [1:0] rl = 2'h0;
    logic [7:0] rt = 8'h00, ra = 8'h00;
    int n_fail = 0, checked = 0, cyc = 0;
    initial forever #10 clk_i = ~clk_i;
    pacc_top pacc_top_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .req_valid_i(rv), .req_write_i(rw), .req_level_i(rl), .req_space_i(rs),
        .req_table_i(rt), .req_addr_i(ra), .req_wdata_i(ra ^ 8'ha5), .mem_rdata_i(mem_rdata),
        .rsp_valid_o(rsp_valid), .rsp_grant_o(rsp_grant), .rsp_rdata_o(rsp_rdata), .mem_we_o(mem_we),
        .mem_space_o(), .mem_table_o(), .mem_addr_o(), .mem_wdata_o());
    pacc_mem_model pacc_mem_model_i (.req_table_i(rt), .req_addr_i(ra), .mem_rdata_o(mem_rdata));
    task test_done;
        if (n_fail == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    task chk_bit(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit
    task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1) @(posedge clk_i);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0000_0000);
        chk_word("prdata", e, rd);
        chk_bit("pslverr", ee, er);
    endtask : rd_chk
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk_bit("pslverr", 1'b0, er);
    endtask : wr
    // c is write, space, level; g is the expected grant
    task hreq(input logic [3:0] c, input logic [7:0] t, input logic [7:0] a, input logic g);
        logic [7:0] xd;
        @(posedge clk_i);
        rv <= 1'b1;
        rw <= c[3];
        rs <= c[2];
        rl <= c[1:0];
        rt <= t;
        ra <= a;
        @(posedge clk_i);
        rv <= 1'b0;
        #1;
        xd = (g && !c[3]) ? (a ^ t ^ 8'h3c) : 8'h00;
        chk_bit("rsp_valid", 1'b1, rsp_valid);
        chk_bit("rsp_grant", g, rsp_grant);
        chk_word("rsp_rdata", {24'h00_0000, xd}, {24'h00_0000, rsp_rdata});
        chk_bit("mem_we", g && c[3] && !(t == 8'h02 && a[7:1] == 7'h60 && !c[2]), mem_we);
    endtask : hreq
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rd_chk(12'h300, 32'h0000_0010, 1'b0);
        rd_chk(12'h304, 32'h0000_0003, 1'b0);
        rd_chk(12'h400, 32'h0000_0000, 1'b1);
        hreq(4'b0_0_01, 8'h01, 8'h80, 1'b1);
        hreq(4'b1_0_01, 8'h01, 8'hbf, 1'b1);
        hreq(4'b0_0_00, 8'h01, 8'h80, 1'b0);
        hreq(4'b0_0_01, 8'h01, 8'hc0, 1'b0);
        hreq(4'b1_1_00, 8'h00, 8'h7f, 1'b1);
        hreq(4'b1_1_11, 8'h00, 8'h80, 1'b1);
        hreq(4'b0_1_00, 8'h00, 8'hff, 1'b1);
        hreq(4'b0_1_00, 8'h00, 8'h7f, 1'b1);
        hreq(4'b1_0_01, 8'h00, 8'h5f, 1'b0);
        hreq(4'b1_0_00, 8'h00, 8'h5f, 1'b0);
        hreq(4'b0_0_00, 8'h00, 8'h00, 1'b1);
        hreq(4'b0_0_10, 8'h02, 8'hb0, 1'b0);
        hreq(4'b1_0_10, 8'h09, 8'h90, 1'b1);
        hreq(4'b1_0_01, 8'h09, 8'h90, 1'b0);
        wr(12'h300, 32'h0000_00ff);
        wr(12'h304, 32'h0000_0000);
        hreq(4'b1_0_01, 8'h07, 8'h80, 1'b1);
        hreq(4'b0_0_01, 8'h08, 8'hff, 1'b1);
        hreq(4'b1_0_01, 8'h01, 8'hf8, 1'b1);
        hreq(4'b1_0_01, 8'h05, 8'hf8, 1'b0);
        hreq(4'b1_0_01, 8'h02, 8'hb5, 1'b1);
        hreq(4'b1_0_01, 8'h02, 8'hb3, 1'b0);
        hreq(4'b1_0_01, 8'h01, 8'hc0, 1'b1);
        hreq(4'b1_0_01, 8'h00, 8'h00, 1'b1);
        hreq(4'b1_1_01, 8'h00, 8'h00, 1'b1);
        hreq(4'b1_1_00, 8'h00, 8'h00, 1'b0);
        hreq(4'b1_1_01, 8'h00, 8'hff, 1'b1);
        hreq(4'b0_1_00, 8'h00, 8'h80, 1'b0);
        hreq(4'b0_0_01, 8'h04, 8'h80, 1'b0);
        wr(12'h300, 32'h0000_0000);
        wr(12'h304, 32'h0000_00ff);
        hreq(4'b1_0_01, 8'h06, 8'h80, 1'b1);
        hreq(4'b0_0_01, 8'h01, 8'hff, 1'b1);
        hreq(4'b1_0_01, 8'h01, 8'hff, 1'b0);
        hreq(4'b0_0_01, 8'h02, 8'hc2, 1'b1);
        hreq(4'b1_0_01, 8'h02, 8'hc2, 1'b0);
        hreq(4'b0_0_01, 8'h01, 8'hbf, 1'b1);
        hreq(4'b1_0_01, 8'h01, 8'h80, 1'b0);
        hreq(4'b0_0_01, 8'h01, 8'hf7, 1'b1);
        hreq(4'b1_0_01, 8'h01, 8'hc0, 1'b0);
        hreq(4'b1_0_01, 8'h02, 8'hb0, 1'b1);
        hreq(4'b0_0_01, 8'h02, 8'hb1, 1'b0);
        hreq(4'b1_1_00, 8'h00, 8'h10, 1'b1);
        hreq(4'b1_0_01, 8'h08, 8'h80, 1'b0);
        wr(12'h308, 32'h0000_0001);
        hreq(4'b0_0_01, 8'h05, 8'hf8, 1'b1);
        hreq(4'b0_0_01, 8'h01, 8'hf8, 1'b0);
        hreq(4'b1_0_10, 8'h02, 8'hc0, 1'b1);
        rd_chk(12'h300, 32'h0000_0065, 1'b0);
        rd_chk(12'h30c, 32'h0000_0412, 1'b0);
        test_done();
    end
endmodule : tb
`default_nettype wire
